// >>> dv/timer8_waveform_control_tb.sv
// timer8_waveform_control_tb.sv: self-checking bench of the 8-bit timer
// assumes tmr_timer8 with its checker bound in, and the pin model beside it
`default_nettype none
`include "tmr_defs.vh"
module timer8_waveform_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk, presetn, ena, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic        pready, pslverr, wf, ovr, drv, ovf, cmf, asel, pad, qerr, exp_w;
   int          miscompares, checked, seed, n, lo, hi;
   int          dv[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
   logic [1:0]  cm[4] = '{2'h2, 2'h3, 2'h1, 2'h1};
   logic [7:0]  fc[3] = '{8'h30, 8'h20, 8'h10};
   logic [7:0]  pw[4] = '{8'h69, 8'h79, 8'h61, 8'h71};
   logic        fx[3] = '{1'b1, 1'b0, 1'b1};
   logic        pv[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
   tmr_timer8 u_tmr_timer8 (.pclk(pclk), .presetn(presetn), .ena(ena), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .waveform_output(wf), .pin_override(ovr), .pin_drive_enable(drv), .overflow_flag(ovf),
      .compare_match_flag(cmf), .async_clock_select(asel));
   tmr_pin_model u_tmr_pin_model (.waveform_output(wf), .pin_override(ovr), .pin_drive_enable(drv),
      .port_level(1'b0), .pad(pad));
   // 100 mhz clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // verdict and end of run
   task automatic test_done();
      if (miscompares == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         miscompares++;
      end
   endtask
   // one apb transfer; request held until ready is sampled
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         miscompares++;
         test_done();
      end
      q = prdata;
      qerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic idle(input int c);
      repeat (c) @(posedge pclk);
   endtask
   task automatic wait_cmf();
      int k;
      for (k = 0; k < 300 && cmf !== 1'b1; k++) @(posedge pclk);
      if (k >= 300) begin
         miscompares++;
         test_done();
      end
   endtask
   // output level after a match in non-pwm modes
   function automatic logic next_w(input logic [1:0] com, input logic w);
      case (com)
         2'h1: next_w = ~w;
         2'h2: next_w = 1'b0;
         default: next_w = 1'b1;
      endcase
   endfunction
   // main sequence
   initial begin
      seed = 32'h5f26;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      ena = 1'b1;
      presetn = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      for (n = 0; n < 4; n++) begin
         apb(1'b0, 12'(n * 4), 32'h0);
         chk("reset_value", 32'h0, q);
      end
      apb(1'b0, 12'h014, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, qerr});
      apb(1'b1, `TMR_ADDR_PIN, 32'h2);
      // forced compares, counter stopped in clear-on-match
      apb(1'b1, `TMR_ADDR_COUNT, 32'h7);
      apb(1'b1, `TMR_ADDR_COMPARE, 32'h7);
      for (n = 0; n < 3; n++) begin
         apb(1'b1, `TMR_ADDR_CTRL, {24'h0, 8'h88 | fc[n]});
         idle(3);
         chk("force_out", {31'h0, fx[n]}, {31'h0, wf});
         chk("pad_level", {31'h0, fx[n]}, {31'h0, pad});
      end
      apb(1'b0, `TMR_ADDR_CTRL, 32'h0);
      chk("ctrl_read", 32'h18, q);
      apb(1'b0, `TMR_ADDR_COUNT, 32'h0);
      chk("force_count", 32'h7, q);
      chk("force_flag", 32'h0, {31'h0, cmf});
      // match actions in normal mode, random compare values
      exp_w = 1'b1;
      for (n = 0; n < 4; n++) begin
         apb(1'b1, `TMR_ADDR_CTRL, {26'h0, cm[n], 4'h0});
         apb(1'b1, `TMR_ADDR_STATUS, 32'h3);
         apb(1'b1, `TMR_ADDR_COUNT, 32'h0);
         apb(1'b1, `TMR_ADDR_COMPARE, 32'($unsigned($random(seed)) % 180 + 20));
         apb(1'b1, `TMR_ADDR_CTRL, {26'h0, cm[n], 4'h1});
         wait_cmf();
         idle(2);
         exp_w = next_w(cm[n], exp_w);
         chk("match_out", {31'h0, exp_w}, {31'h0, wf});
      end
      // a counter write hides the match on the next tick
      apb(1'b1, `TMR_ADDR_CTRL, 32'h0);
      apb(1'b1, `TMR_ADDR_STATUS, 32'h3);
      apb(1'b1, `TMR_ADDR_COMPARE, 32'h40);
      apb(1'b1, `TMR_ADDR_COUNT, 32'h40);
      apb(1'b1, `TMR_ADDR_CTRL, 32'h1);
      idle(20);
      chk("blocked_match", 32'h0, {31'h0, cmf});
      apb(1'b1, `TMR_ADDR_COUNT, 32'hfa);
      idle(12);
      apb(1'b0, `TMR_ADDR_STATUS, 32'h0);
      chk("overflow", 32'h1, q & 32'h1);
      apb(1'b1, `TMR_ADDR_STATUS, 32'h1);
      idle(2);
      chk("ovf_clear", 32'h0, {31'h0, ovf});
      // clear-on-match keeps the count at or below compare
      apb(1'b1, `TMR_ADDR_CTRL, 32'h8);
      apb(1'b1, `TMR_ADDR_COMPARE, 32'h9);
      apb(1'b1, `TMR_ADDR_COUNT, 32'h0);
      apb(1'b1, `TMR_ADDR_STATUS, 32'h3);
      apb(1'b1, `TMR_ADDR_CTRL, 32'h9);
      repeat (8) begin
         idle(1 + $unsigned($random(seed)) % 15);
         apb(1'b0, `TMR_ADDR_COUNT, 32'h0);
         chk("ctc_count", 32'h1, {31'h0, q <= 32'h9});
      end
      chk("ctc_flag", 32'h1, {31'h0, cmf});
      chk("ctc_no_ovf", 32'h0, {31'h0, ovf});
      // every clock select, twenty ticks each except select 0, which must stay stopped
      for (n = 0; n < 8; n++) begin
         apb(1'b1, `TMR_ADDR_CTRL, 32'h0);
         apb(1'b1, `TMR_ADDR_COUNT, 32'h0);
         apb(1'b1, `TMR_ADDR_CTRL, 32'(n));
         idle(dv[n] * 20 + 50 * (n == 0));
         apb(1'b1, `TMR_ADDR_CTRL, 32'h0);
         apb(1'b0, `TMR_ADDR_COUNT, 32'h0);
         lo = (n == 0) ? 0 : 19;
         hi = (n == 0) ? 0 : 25;
         chk("prescale", 32'h1, {31'h0, q >= lo && q <= hi});
      end
      // pwm with compare at top, clock enable jittered
      apb(1'b1, `TMR_ADDR_COMPARE, 32'hff);
      for (n = 0; n < 4; n++) begin
         apb(1'b1, `TMR_ADDR_CTRL, {24'h0, pw[n]});
         idle(600);
         repeat (30) begin
            ena <= ($random(seed) % 4) != 0;
            idle(1 + $unsigned($random(seed)) % 20);
            chk("pwm_top", {31'h0, pv[n]}, {31'h0, wf});
         end
         ena <= 1'b1;
      end
      // driver off: pad falls back to its pull-up
      apb(1'b1, `TMR_ADDR_PIN, 32'h1);
      idle(3);
      chk("pad_released", 32'h1, {31'h0, pad});
      chk("async_select", 32'h1, {31'h0, asel});
      chk("override_level", 32'h1, {31'h0, ovr});
      test_done();
   end
endmodule // timer8_waveform_control_tb
`default_nettype wire

// >>> dv/tmr_pin_model.sv
// tmr_pin_model.sv: pad beside the timer's waveform pin
// assumes a pull-up on the pad and a port data level from the bench
`default_nettype none
module tmr_pin_model (
   // from the timer
   input  wire logic waveform_output,
   input  wire logic pin_override,
   input  wire logic pin_drive_enable,
   // normal port data
   input  wire logic port_level,
   // resolved pad
   output var  logic pad
);
   timeunit 1ns;
   timeprecision 1ns;
   // undriven pad floats up, so a stale level can never pass
   always_comb pad = pin_drive_enable ? (pin_override ? waveform_output : port_level) : 1'b1;
endmodule // tmr_pin_model
`default_nettype wire

// >>> dv/tmr_timer8_assertions.sv
// tmr_timer8_assertions.sv: port checker for the 8-bit timer
// assumes binding onto tmr_timer8, one pclk domain, apb as in the hand-over
`default_nettype none
`include "tmr_defs.vh"
module tmr_timer8_chk (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        ena,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // pin and status
   input wire logic        waveform_output,
   input wire logic        pin_override,
   input wire logic        pin_drive_enable,
   input wire logic        overflow_flag,
   input wire logic        compare_match_flag,
   input wire logic        async_clock_select
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // completed write at the access edge
   wire wr_acc = psel && penable && pwrite && pready;
   answer_one_cycle_a: assert property (psel && !penable && ena |=> pready) else $error("no answer after setup");
   ready_after_setup_a: assert property (pready |-> $past(psel && !penable)) else $error("stray ready");
   err_with_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
   err_read_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("error read not 0");
   force_reads_zero_a: assert property (pready && !pwrite && paddr == `TMR_ADDR_CTRL |-> prdata[31:7] == 25'h0)
      else $error("force bit read back");
   override_on_a: assert property (wr_acc && paddr == `TMR_ADDR_CTRL && pwdata[5:4] != 2'h0 |-> ##[1:2] pin_override)
      else $error("override missing");
   override_off_a: assert property (wr_acc && paddr == `TMR_ADDR_CTRL && pwdata[5:4] == 2'h0 |-> ##[1:2] !pin_override)
      else $error("override stuck");
   ovf_sticky_a: assert property (overflow_flag && !(wr_acc && paddr == `TMR_ADDR_STATUS && pwdata[0]) |=> overflow_flag)
      else $error("overflow flag lost");
   cmf_sticky_a: assert property (compare_match_flag && !(wr_acc && paddr == `TMR_ADDR_STATUS && pwdata[1])
      |=> compare_match_flag) else $error("compare flag lost");
   freeze_a: assert property (!ena |=> $stable(waveform_output) && $stable(overflow_flag))
      else $error("state moved while disabled");
endmodule // tmr_timer8_chk
bind tmr_timer8 tmr_timer8_chk u_tmr_timer8_chk (.pclk(pclk), .presetn(presetn), .ena(ena), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .waveform_output(waveform_output), .pin_override(pin_override),
   .pin_drive_enable(pin_drive_enable), .overflow_flag(overflow_flag), .compare_match_flag(compare_match_flag),
   .async_clock_select(async_clock_select));
`default_nettype wire

// >>> hw/tmr_defs.vh
// tmr_defs.vh: register map, field positions and codes of the 8-bit timer
// assumes inclusion by bare name from the timer design files
`ifndef TMR_DEFS_VH
`define TMR_DEFS_VH

// apb byte addresses
`define TMR_ADDR_CTRL     12'h000
`define TMR_ADDR_COUNT    12'h004
`define TMR_ADDR_COMPARE  12'h008
`define TMR_ADDR_STATUS   12'h00c
`define TMR_ADDR_PIN      12'h010

// counter_control field positions
`define TMR_BIT_FORCE     7
`define TMR_BIT_WGM0      6
`define TMR_BIT_COM1      5
`define TMR_BIT_COM0      4
`define TMR_BIT_WGM1      3
`define TMR_CS_HI         2
`define TMR_CS_LO         0

// status / pin register bits
`define TMR_BIT_OVF       0
`define TMR_BIT_CMF       1
`define TMR_BIT_ASYNC     0
`define TMR_BIT_DIR       1

// reset values
`define TMR_CTRL_RST      8'h00
`define TMR_COUNT_RST     8'h00
`define TMR_COMPARE_RST   8'h00

// waveform modes
`define TMR_MODE_NORMAL   2'h0
`define TMR_MODE_PCPWM    2'h1
`define TMR_MODE_CTC      2'h2
`define TMR_MODE_FPWM     2'h3

`define TMR_MAX           8'hff
`define TMR_BOTTOM        8'h00

// prescaler taps: divide by 8,32,64,128,256,1024 ends at bit n
`define TMR_PRE_W         10

`endif

// >>> hw/tmr_prescaler.v
// tmr_prescaler.v: free running prescaler and clock-select tick generator
// assumes a single clock domain; ena is the chip clock enable
`default_nettype none
`include "tmr_defs.vh"

module tmr_prescaler (
   // clock and reset
   input  wire       pclk,
   input  wire       presetn,
   input  wire       ena,
   // selection
   input  wire [2:0] clock_select_bits,
   // tick out
   output reg        timer_tick_enable
);

   reg  [`TMR_PRE_W-1:0] pre_cnt;
   wire [`TMR_PRE_W-1:0] next_pre_cnt;
   reg                   next_tick;

   assign next_pre_cnt = pre_cnt + {{(`TMR_PRE_W-1){1'b0}}, 1'b1};

   // tick on the cycle the counter wraps to the tap boundary
   function is_wrap;
      input [`TMR_PRE_W-1:0] c;
      input integer          bits;
      integer                i;
      begin
         is_wrap = 1'b1;
         for (i = 0; i < `TMR_PRE_W; i = i + 1) begin
            if (i < bits && c[i] != 1'b1) is_wrap = 1'b0;
         end
      end
   endfunction

   // clock select decoding: 000 stops, 001 undivided, then /8../1024
   always @* begin
      case (clock_select_bits)
         3'h0:    next_tick = 1'b0;
         3'h1:    next_tick = 1'b1;
         3'h2:    next_tick = is_wrap(pre_cnt, 3);
         3'h3:    next_tick = is_wrap(pre_cnt, 5);
         3'h4:    next_tick = is_wrap(pre_cnt, 6);
         3'h5:    next_tick = is_wrap(pre_cnt, 7);
         3'h6:    next_tick = is_wrap(pre_cnt, 8);
         default: next_tick = is_wrap(pre_cnt, 10);
      endcase
   end

   // prescaler is shared-style free running, so a restart is not phase aligned
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt           <= {`TMR_PRE_W{1'b0}};
         timer_tick_enable <= 1'b0;
      end else if (ena) begin
         pre_cnt           <= next_pre_cnt;
         timer_tick_enable <= next_tick;
      end
   end

endmodule // tmr_prescaler
`default_nettype wire

// >>> hw/tmr_timer8.v
// tmr_timer8.v: 8-bit timer/counter with compare unit and waveform output
// assumes apb master on pclk; oscillator clock, if used, is the pclk source
//
// Operation
// - writing force bit in non-pwm mode forces compare action on the output
// - forced compare sets no flag and never clears the counter
// - force bit is a strobe and reads back as zero
// - mode bits 6 and 3: normal, phase pwm, clear-on-match, fast pwm
// - compare buffer loads immediately, at top or bottom; overflow per mode
// - nonzero output mode overrides port; driver enabled by direction bit
// - non-pwm output modes: off, toggle, clear, set on match
// - fast pwm: off, reserved, clear-match/set-bottom, set-match/clear-bottom
// - fast pwm, compare equals top: match ignored, only bottom action
// - phase pwm, compare equals top: match ignored, only top action
// - phase pwm: clear up-match set down-match, or the opposite
// - clock select: stop, undivided, or divide by 8,32,64,128,256,1024
// - counter read/write; a write blocks the match on the next tick
// - compare register compared continuously; match sets flag, drives output
// - logic fully synchronous, timer tick acts as clock enable
// - clear-on-match: match sets flag and clears counter on next tick
// - clock source select bit picks io clock or oscillator
`default_nettype none
`include "tmr_defs.vh"

module tmr_timer8 (
   // clock, reset, clock enable
   input  wire        pclk,
   input  wire        presetn,
   input  wire        ena,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // waveform pin
   output reg         waveform_output,
   output reg         pin_override,
   output reg         pin_drive_enable,
   // status levels
   output reg         overflow_flag,
   output reg         compare_match_flag,
   output reg         async_clock_select
);

   reg  [7:0] counter_control;
   reg  [7:0] count_value;
   reg  [7:0] compare_value;   // software-visible buffer
   reg  [7:0] compare_active;  // value the comparator uses
   reg        count_down;
   reg        block_match;
   reg        match_pend;      // counter sat on a match during last tick window
   reg        port_dir;
   reg        wave_q;
   reg        next_wave;
   reg  [7:0] next_count;
   reg        next_down;
   reg  [31:0] next_rdata;
   reg        addr_ok;

   wire       timer_tick_enable;
   wire [1:0] waveform_mode_bits;
   wire [1:0] compare_output_mode_bits;
   wire [2:0] clock_select_bits;
   wire       is_pwm;
   wire       cmp_eq;
   wire       wr_access;
   wire       rd_access;
   wire       wr_ctrl;
   wire       force_compare_strobe;
   wire       pwm_top_special;
   wire [7:0] top_value;

   // field decode, mode bits split across positions 6 and 3
   assign waveform_mode_bits       = {counter_control[`TMR_BIT_WGM1],
                                      counter_control[`TMR_BIT_WGM0]};
   assign compare_output_mode_bits = {counter_control[`TMR_BIT_COM1],
                                      counter_control[`TMR_BIT_COM0]};
   assign clock_select_bits        = counter_control[`TMR_CS_HI:`TMR_CS_LO];
   assign is_pwm     = waveform_mode_bits[0];
   assign top_value  = (waveform_mode_bits == `TMR_MODE_CTC) ? compare_active : `TMR_MAX;
   assign cmp_eq     = (count_value == compare_active);
   assign pwm_top_special = compare_output_mode_bits[1] && (compare_active == `TMR_MAX);

   // apb strobes, zero wait state: access phase completes when ena was high at the setup edge
   assign wr_access = psel && penable && pwrite;
   assign rd_access = psel && penable && !pwrite;
   assign wr_ctrl   = wr_access && (paddr == `TMR_ADDR_CTRL);
   // strobe only, ignored in pwm modes; decoded from the word being written so a
   // single write can pick the output mode and force it at once
   assign force_compare_strobe = wr_ctrl && pwdata[`TMR_BIT_FORCE]
                                 && !pwdata[`TMR_BIT_WGM0];

   // prescaler tick; oscillator selection only changes the pclk source upstream
   tmr_prescaler u_pre (
      .pclk              (pclk),
      .presetn           (presetn),
      .ena               (ena),
      .clock_select_bits (clock_select_bits),
      .timer_tick_enable (timer_tick_enable)
   );

   // counter sequence per mode
   always @* begin
      next_count = count_value;
      next_down  = count_down;
      case (waveform_mode_bits)
         `TMR_MODE_PCPWM: begin
            if (!count_down) begin
               if (count_value == `TMR_MAX) begin
                  next_down  = 1'b1;
                  next_count = count_value - 8'h01;
               end else begin
                  next_count = count_value + 8'h01;
               end
            end else begin
               if (count_value == `TMR_BOTTOM) begin
                  next_down  = 1'b0;
                  next_count = count_value + 8'h01;
               end else begin
                  next_count = count_value - 8'h01;
               end
            end
         end
         `TMR_MODE_CTC: begin
            // clear only on a real match after its tick
            if (cmp_eq && !block_match)
               next_count = `TMR_BOTTOM;
            else
               next_count = count_value + 8'h01;
            next_down = 1'b0;
         end
         default: begin
            next_count = count_value + 8'h01;
            next_down  = 1'b0;
         end
      endcase
   end

   // waveform generator: one process so forced and real matches share a driver
   always @* begin
      next_wave = wave_q;
      if (force_compare_strobe) begin
         case ({pwdata[`TMR_BIT_COM1], pwdata[`TMR_BIT_COM0]})
            2'h1:    next_wave = ~wave_q;
            2'h2:    next_wave = 1'b0;
            2'h3:    next_wave = 1'b1;
            default: next_wave = wave_q;
         endcase
      end else if (timer_tick_enable) begin
         case (waveform_mode_bits)
            `TMR_MODE_FPWM: begin
               // bottom action at max->bottom, match ignored when compare is top
               if (count_value == `TMR_MAX && compare_output_mode_bits[1])
                  next_wave = ~compare_output_mode_bits[0];
               else if (cmp_eq && !block_match && !pwm_top_special && compare_output_mode_bits[1])
                  next_wave = compare_output_mode_bits[0];
            end
            `TMR_MODE_PCPWM: begin
               if (compare_output_mode_bits[1]) begin
                  if (pwm_top_special) begin
                     // only the top action, the level a down-count match gives,
                     // so the output stays constant with compare at top
                     if (count_value == `TMR_MAX)
                        next_wave = ~compare_output_mode_bits[0];
                  end else if (cmp_eq && !block_match) begin
                     // up match clears for 10, down match sets
                     next_wave = count_down ? ~compare_output_mode_bits[0]
                                            : compare_output_mode_bits[0];
                  end
               end
            end
            default: begin
               if (cmp_eq && !block_match) begin
                  case (compare_output_mode_bits)
                     2'h1:    next_wave = ~wave_q;
                     2'h2:    next_wave = 1'b0;
                     2'h3:    next_wave = 1'b1;
                     default: next_wave = wave_q;
                  endcase
               end
            end
         endcase
      end
   end

   // counter, compare buffer, flags; counting updates qualified by the timer tick, register writes not
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter_control    <= `TMR_CTRL_RST;
         count_value        <= `TMR_COUNT_RST;
         compare_value      <= `TMR_COMPARE_RST;
         compare_active     <= `TMR_COMPARE_RST;
         count_down         <= 1'b0;
         block_match        <= 1'b0;
         match_pend         <= 1'b0;
         wave_q             <= 1'b0;
         overflow_flag      <= 1'b0;
         compare_match_flag <= 1'b0;
         async_clock_select <= 1'b0;
         port_dir           <= 1'b0;
      end else if (ena) begin
         wave_q <= next_wave;
         // force bit never stored
         if (wr_ctrl)
            counter_control <= {1'b0, pwdata[6:0]};
         if (wr_access && paddr == `TMR_ADDR_COMPARE) begin
            compare_value <= pwdata[7:0];
            if (!is_pwm)
               compare_active <= pwdata[7:0];
         end
         if (wr_access && paddr == `TMR_ADDR_PIN) begin
            async_clock_select <= pwdata[`TMR_BIT_ASYNC];
            port_dir           <= pwdata[`TMR_BIT_DIR];
         end
         // status flags cleared by writing one; hardware set wins below
         if (wr_access && paddr == `TMR_ADDR_STATUS) begin
            if (pwdata[`TMR_BIT_OVF]) overflow_flag      <= 1'b0;
            if (pwdata[`TMR_BIT_CMF]) compare_match_flag <= 1'b0;
         end
         if (wr_access && paddr == `TMR_ADDR_COUNT) begin
            count_value <= pwdata[7:0];
            block_match <= 1'b1;
            match_pend  <= 1'b0;
         end else if (timer_tick_enable) begin
            count_value <= next_count;
            count_down  <= next_down;
            block_match <= 1'b0;
            // flags as the counter leaves the triggering value
            if (cmp_eq && !block_match)
               compare_match_flag <= 1'b1;
            if (waveform_mode_bits == `TMR_MODE_PCPWM) begin
               if (count_value == `TMR_BOTTOM && count_down)
                  overflow_flag <= 1'b1;
               if (count_value == `TMR_MAX)
                  compare_active <= compare_value;
            end else begin
               if (count_value == `TMR_MAX || (next_count == `TMR_BOTTOM && count_value == top_value
                   && waveform_mode_bits == `TMR_MODE_CTC && top_value == `TMR_MAX))
                  overflow_flag <= 1'b1;
               if (waveform_mode_bits == `TMR_MODE_FPWM && count_value == `TMR_MAX)
                  compare_active <= compare_value;
            end
            match_pend <= cmp_eq;
         end
         // leaving pwm mode makes the buffer transparent again
         if (!is_pwm && !(wr_access && paddr == `TMR_ADDR_COMPARE))
            compare_active <= compare_value;
      end
   end

   // apb read mux
   always @* begin
      next_rdata = 32'h0000_0000;
      addr_ok    = 1'b1;
      case (paddr)
         `TMR_ADDR_CTRL:    next_rdata = {24'h00_0000, 1'b0, counter_control[6:0]};
         `TMR_ADDR_COUNT:   next_rdata = {24'h00_0000, count_value};
         `TMR_ADDR_COMPARE: next_rdata = {24'h00_0000, compare_value};
         `TMR_ADDR_STATUS:  next_rdata = {30'h0000_0000, compare_match_flag, overflow_flag};
         `TMR_ADDR_PIN:     next_rdata = {30'h0000_0000, port_dir, async_clock_select};
         default:           addr_ok    = 1'b0;
      endcase
   end

   // registered apb answer: pready one cycle after setup, so no wait state
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (ena) begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         prdata  <= (psel && !penable && !pwrite) ? next_rdata : 32'h0000_0000;
      end
   end

   // pin outputs registered; override whenever any output mode bit set
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         waveform_output  <= 1'b0;
         pin_override     <= 1'b0;
         pin_drive_enable <= 1'b0;
      end else if (ena) begin
         waveform_output  <= next_wave;
         pin_override     <= |compare_output_mode_bits;
         pin_drive_enable <= port_dir;
      end
   end

   // rd_access kept for symmetry of decode; match_pend is read by no other logic
   wire unused_ok = rd_access & match_pend;

endmodule // tmr_timer8
`default_nettype wire
